// file: hw/clocked_serial_port_8bit.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module clocked_serial_port_8bit
  import serial_port_pkg::*;
#(
  parameter bit NEG_POLARITY = 1'b0
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              slow_osc_clock_i,
  input  wire logic              timer2_underflow_i,
  input  wire logic              serial_in_pin_i,
  input  wire logic              sclk_pin_i,
  output logic                   sclk_pin_o,
  output logic                   sclk_pin_oe_n_o,
  output logic                   serial_out_pin_o,
  output logic                   serial_out_route_o,
  output logic                   input_pin_pulldown_o,
  output logic                   clock_pin_pulldown_o,
  output logic                   serial_function_o,
  output logic                   slave_ready_pin_o,
  output logic                   serial_irq_o
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a[ADDR_W-1:2] == idx;
  endfunction

  // Pin synchronisers: osc, clock pin, data pin.
  logic [2:0] async_in;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  assign async_in = {serial_in_pin_i, sclk_pin_i, slow_osc_clock_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (ce_i) begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // Registers.
  logic   in_pd_q, clk_pd_q, func_en_q, out_en_q, irq_en_q, irq_flag_q, irq_q;
  mode_t  mode_q;
  state_t state_q;
  logic   armed_q;
  logic   [7:0] sh_q, sh_d;
  logic   [3:0] cnt_q;
  logic   sample_bit_q, serial_out_pin_q, osc_q, mclk_q, prev_q;

  // Bus write and read paths.
  logic              aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [3:0]        w_nib_q;
  logic              w_lane_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [3:0]        rdata_q;

  wire wr_fire = ce_i & aw_hold_q & w_hold_q & ~bvalid_q;
  wire wr_en   = wr_fire & w_lane_q;
  wire rd_fire = ce_i & s_axi_arvalid & ~rvalid_q;

  wire wr_pd    = wr_en & hit(aw_addr_q, IDX_PULLDOWN);
  wire wr_trig  = wr_en & hit(aw_addr_q, IDX_TRIGGER);
  wire wr_mode  = wr_en & hit(aw_addr_q, IDX_MODE);
  wire wr_lo    = wr_en & hit(aw_addr_q, IDX_DATA_LO);
  wire wr_hi    = wr_en & hit(aw_addr_q, IDX_DATA_HI);
  wire wr_mask  = wr_en & hit(aw_addr_q, IDX_IRQ_MASK);
  wire wr_flag  = wr_en & hit(aw_addr_q, IDX_IRQ_FLAG);
  wire rd_data  = rd_fire & (hit(s_axi_araddr, IDX_DATA_LO) | hit(s_axi_araddr, IDX_DATA_HI));

  wire wr_mapped = hit(aw_addr_q, IDX_PULLDOWN) | hit(aw_addr_q, IDX_TRIGGER)
                 | hit(aw_addr_q, IDX_MODE) | hit(aw_addr_q, IDX_DATA_LO)
                 | hit(aw_addr_q, IDX_DATA_HI) | hit(aw_addr_q, IDX_IRQ_MASK)
                 | hit(aw_addr_q, IDX_IRQ_FLAG);

  // Ready drops with the clock enable, so no handshake completes while the bus is frozen.
  assign s_axi_awready = ce_i & ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ce_i & ~w_hold_q & ~bvalid_q;
  assign s_axi_arready = ce_i & ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {28'h0000000, rdata_q};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_hold_q <= 1'b0;
      w_nib_q  <= 4'h0;
      w_lane_q <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_nib_q  <= s_axi_wdata[3:0];
        w_lane_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data mux.
  logic       running;
  logic [3:0] rd_value;
  logic       rd_mapped;
  assign running = (state_q == ST_RUN);

  always_comb begin
    rd_value  = 4'h0;
    rd_mapped = 1'b1;
    if (hit(s_axi_araddr, IDX_PULLDOWN)) begin
      rd_value = {1'b0, clk_pd_q, 1'b0, in_pd_q};
    end else if (hit(s_axi_araddr, IDX_TRIGGER)) begin
      rd_value = {1'b0, out_en_q, running, func_en_q};
    end else if (hit(s_axi_araddr, IDX_MODE)) begin
      rd_value = mode_q;
    end else if (hit(s_axi_araddr, IDX_DATA_LO)) begin
      rd_value = sh_q[3:0];
    end else if (hit(s_axi_araddr, IDX_DATA_HI)) begin
      rd_value = sh_q[7:4];
    end else if (hit(s_axi_araddr, IDX_IRQ_MASK)) begin
      rd_value = {3'h0, irq_en_q};
    end else if (hit(s_axi_araddr, IDX_IRQ_FLAG)) begin
      rd_value = {3'h0, irq_flag_q};
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 4'h0;
    end else if (ce_i) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= rd_value;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Control registers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_pd_q   <= RST_PULLDOWN;
      clk_pd_q  <= RST_PULLDOWN;
      mode_q    <= mode_t'(RST_MODE);
      func_en_q <= 1'b0;
      out_en_q  <= 1'b0;
      irq_en_q  <= 1'b0;
    end else if (ce_i) begin
      if (wr_pd) begin
        in_pd_q  <= w_nib_q[BIT_IN_PD];
        clk_pd_q <= w_nib_q[BIT_CLK_PD];
      end
      if (wr_mode) begin
        mode_q <= mode_t'(w_nib_q);
      end
      if (wr_trig) begin
        func_en_q <= w_nib_q[BIT_FUNC_EN];
        out_en_q  <= w_nib_q[BIT_OUT_EN];
      end
      if (wr_mask) begin
        irq_en_q <= w_nib_q[BIT_IRQ];
      end
    end
  end

  // Shift clock generation and edge detection.
  // The internal clock idles high so the first edge of a run is a fall, which never shifts.
  wire master    = (mode_q.clock_source_sel != SRC_SLAVE);
  wire osc_rise  = sync2_q[0] & ~osc_q;
  wire osc_fall  = ~sync2_q[0] & osc_q;
  wire timer_ev  = ce_i & timer2_underflow_i;
  logic tick;

  always_comb begin
    case (mode_q.clock_source_sel)
      SRC_OSC:      tick = osc_rise | osc_fall;
      SRC_OSC_HALF: tick = osc_rise;
      SRC_TIMER:    tick = timer_ev;
      default:      tick = 1'b0;
    endcase
  end

  wire slave_clk = sync2_q[1] ^ NEG_POLARITY;
  wire cur_clk   = master ? mclk_q : slave_clk;
  wire rise      = ce_i & cur_clk & ~prev_q;
  wire fall      = ce_i & ~cur_clk & prev_q;
  // Inversion of the pin clock makes both phase meanings land on the same internal edge.
  wire sample_ev = running & (mode_q.sample_edge_sel ? rise : fall);
  wire shift_ev  = running & rise;
  wire done      = shift_ev & (cnt_q == LAST_BIT_CNT);
  wire start     = wr_trig & w_nib_q[BIT_TRIGGER] & ~running & armed_q & func_en_q;
  wire sin_bit   = sync2_q[2];
  wire in_bit    = mode_q.sample_edge_sel ? sin_bit : sample_bit_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_q  <= 1'b0;
      prev_q <= 1'b1;
    end else if (ce_i) begin
      osc_q  <= sync2_q[0];
      prev_q <= cur_clk;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mclk_q <= 1'b1;
    end else if (ce_i) begin
      if (!running || !master) begin
        mclk_q <= 1'b1;
      end else if (tick && !(mclk_q && cnt_q == 4'h8)) begin
        mclk_q <= ~mclk_q;
      end
    end
  end

  // Transfer state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      armed_q <= 1'b0;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE: begin
          if (wr_lo || wr_hi || rd_data) begin
            armed_q <= 1'b1;
          end
          if (start) begin
            state_q <= ST_RUN;
            cnt_q   <= 4'h0;
            armed_q <= 1'b0;
          end
        end
        ST_RUN: begin
          if (done) begin
            state_q <= ST_IDLE;
          end else if (shift_ev) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Shared shift register: one sampled bit enters for each bit that leaves.
  always_comb begin
    sh_d = sh_q;
    if (shift_ev) begin
      if (mode_q.bit_order_sel) begin
        sh_d = {sh_q[6:0], in_bit};
      end else begin
        sh_d = {in_bit, sh_q[7:1]};
      end
    end else if (!running) begin
      if (wr_lo) begin
        sh_d[3:0] = w_nib_q;
      end
      if (wr_hi) begin
        sh_d[7:4] = w_nib_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q         <= 8'h00;
      serial_out_pin_q       <= 1'b0;
      sample_bit_q <= 1'b0;
    end else if (ce_i) begin
      sh_q   <= sh_d;
      serial_out_pin_q <= mode_q.bit_order_sel ? sh_d[7] : sh_d[0];
      if (sample_ev) begin
        sample_bit_q <= sin_bit;
      end
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flag_q <= 1'b0;
      irq_q      <= 1'b0;
    end else if (ce_i) begin
      irq_flag_q <= done | (irq_flag_q & ~(wr_flag & w_nib_q[BIT_IRQ]));
      irq_q      <= irq_flag_q & irq_en_q;
    end
  end

  assign serial_irq_o         = irq_q;
  assign serial_out_pin_o     = serial_out_pin_q;
  assign serial_out_route_o   = func_en_q & out_en_q;
  assign serial_function_o    = func_en_q;
  assign slave_ready_pin_o    = func_en_q & ~master & running;
  assign sclk_pin_o           = mclk_q ^ NEG_POLARITY;
  assign sclk_pin_oe_n_o      = ~(func_en_q & master);
  assign input_pin_pulldown_o = in_pd_q;
  assign clock_pin_pulldown_o = clk_pd_q & ~master;

  chk_flag_on_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done |=> irq_flag_q) else $error("flag not set after transfer");
  chk_flag_w1c: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_flag && w_nib_q[BIT_IRQ] && !done) |=> !irq_flag_q) else $error("flag not cleared");
  chk_irq_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !irq_en_q) |=> !serial_irq_o) else $error("masked irq reached output");
  chk_trig_status: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |=> running && cnt_q == 4'h0) else $error("trigger did not start run");
  chk_eight_counts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (shift_ev && cnt_q != LAST_BIT_CNT) |=> running) else $error("run ended early");
  chk_run_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done |=> !running) else $error("status still set after eighth clock");
  chk_out_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (running && $changed(serial_out_pin_q)) |-> $past(shift_ev)) else $error("output moved off edge");
  chk_msb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (shift_ev && mode_q.bit_order_sel) |=> sh_q[0] == $past(in_bit))
    else $error("msb-first shift wrong");
  chk_clk_pd_slave: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clock_pin_pulldown_o |-> !master && clk_pd_q) else $error("clock pulldown in master mode");
  chk_no_zero_trig: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!running && !start) |=> !running) else $error("run began without trigger");

endmodule

// file: pkg/serial_port_pkg.sv
package serial_port_pkg;

  // Byte address is four times the register index.
  localparam int          ADDR_W       = 18;
  localparam logic [15:0] IDX_PULLDOWN = 16'hff45;
  localparam logic [15:0] IDX_TRIGGER  = 16'hff70;
  localparam logic [15:0] IDX_MODE     = 16'hff71;
  localparam logic [15:0] IDX_DATA_LO  = 16'hff72;
  localparam logic [15:0] IDX_DATA_HI  = 16'hff73;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hffe2;
  localparam logic [15:0] IDX_IRQ_FLAG = 16'hfff2;

  localparam int BIT_IN_PD    = 0;
  localparam int BIT_CLK_PD   = 2;
  localparam int BIT_FUNC_EN  = 0;
  localparam int BIT_TRIGGER  = 1;
  localparam int BIT_OUT_EN   = 2;
  localparam int BIT_IRQ      = 0;

  localparam logic       RST_PULLDOWN = 1'b1;
  localparam logic [3:0] RST_MODE     = 4'h0;
  localparam logic [3:0] LAST_BIT_CNT = 4'h7;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    SRC_SLAVE    = 2'b00,
    SRC_TIMER    = 2'b01,
    SRC_OSC_HALF = 2'b10,
    SRC_OSC      = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic     bit_order_sel;
    logic     sample_edge_sel;
    clk_src_t clock_source_sel;
  } mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } state_t;

endpackage

// file: sim/clocked_serial_port_8bit_tb_top.sv
`timescale 1ns/1ps
module clocked_serial_port_8bit_tb_top;
  import serial_port_pkg::*;
  localparam int OSC_HALF = 16;
  localparam int TMR_P    = 10;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata, rv, rv2;
  logic              awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic              ce = 1'b1, bready = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, rs;
  logic              slow_osc = 1'b0, tmr_pulse = 1'b0, sclk_prev = 1'b1;
  logic              sclk_dut, oe_n, serial_out_pin, route, in_pd, clk_pd, func, slave_ready_pin, irq;
  logic              sclk_w, sin_w, peer_sclk;
  logic              p_slave = 1'b1, p_rise = 1'b0, p_msb = 1'b0, p_arm = 1'b0, p_go = 1'b0;
  logic [7:0]        p_tx = 8'h00, p_rx;
  logic [3:0]        p_falls;
  int                tick = 0, gap_cnt = 0, last_gap = 0, n_fail = 0, n_checks = 0;

  always #4 clk_i = ~clk_i;
  assign sclk_w = !oe_n ? sclk_dut : peer_sclk;

  clocked_serial_port_8bit #(.NEG_POLARITY(1'b0)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .slow_osc_clock_i(slow_osc), .timer2_underflow_i(tmr_pulse), .serial_in_pin_i(sin_w),
    .sclk_pin_i(sclk_w), .sclk_pin_o(sclk_dut), .sclk_pin_oe_n_o(oe_n),
    .serial_out_pin_o(serial_out_pin), .serial_out_route_o(route), .input_pin_pulldown_o(in_pd),
    .clock_pin_pulldown_o(clk_pd), .serial_function_o(func), .slave_ready_pin_o(slave_ready_pin),
    .serial_irq_o(irq));

  serial_peer_model #(.HALF(63)) peer (
    .clk_i(clk_i), .slave_i(p_slave), .rise_i(p_rise), .msb_i(p_msb), .tx_i(p_tx),
    .arm_i(p_arm), .go_i(p_go), .sclk_i(sclk_w), .serial_out_pin_i(serial_out_pin), .in_pd_i(in_pd),
    .clk_pd_i(clk_pd), .sclk_o(peer_sclk), .sin_o(sin_w), .rx_o(p_rx), .falls_o(p_falls));

  always @(posedge clk_i) begin
    tick <= tick + 1;
    if (tick % OSC_HALF == OSC_HALF - 1) slow_osc <= ~slow_osc;
    tmr_pulse <= (tick % TMR_P == TMR_P - 1);
    sclk_prev <= sclk_dut;
    gap_cnt   <= gap_cnt + 1;
    if (sclk_prev && !sclk_dut) begin
      last_gap <= gap_cnt;
      gap_cnt  <= 1;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [3:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {28'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [15:0] idx);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
    rd(idx);
    check(what, exp, rv);
  endtask

  function automatic logic [7:0] wire_order(input logic [7:0] b, input logic msb);
    for (int i = 0; i < 8; i++) wire_order[i] = msb ? b[i] : b[7-i];
  endfunction

  function automatic int exp_period(input clk_src_t s);
    case (s)
      SRC_OSC:      return 2 * OSC_HALF;
      SRC_OSC_HALF: return 4 * OSC_HALF;
      default:      return 2 * TMR_P;
    endcase
  endfunction

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // The longest transfer is about 1000 cycles; eight of them fit well inside this span.
  initial begin
    #(40000 * 8);
    n_fail++;
    test_done();
  end

  initial begin
    clk_src_t    src;
    logic [31:0] rnd;
    logic [7:0]  tx, ptx;
    void'($urandom(32'hc237));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(IDX_PULLDOWN);
    check("pulldown", 32'h5, rv & 32'h5);
    rdchk(IDX_MODE, 32'h0, "mode");
    rdchk(IDX_TRIGGER, 32'h0, "trigger");
    rdchk(IDX_IRQ_MASK, 32'h0, "mask");
    rdchk(IDX_IRQ_FLAG, 32'h0, "flag");
    check("pd pins", 32'h3, {30'h0, in_pd, clk_pd});
    // A write offered while the enable is low must not land until it returns.
    ce <= 1'b0;
    fork
      wr(IDX_PULLDOWN, 4'h0);
      begin
        repeat (5) @(posedge clk_i);
        check("frozen pd", 32'h3, {30'h0, in_pd, clk_pd});
        ce <= 1'b1;
      end
    join
    rd(IDX_PULLDOWN);
    check("pd off", 32'h0, {30'h0, in_pd, clk_pd});
    wr(IDX_PULLDOWN, 4'h5);
    wr(16'h0000, 4'hf);
    check("bad wr", 32'(RESP_SLVERR), 32'(rs));
    rd(16'h0000);
    check("bad rd", {30'h0, RESP_SLVERR}, {rv[29:0], rs});
    for (int i = 0; i < 8; i++) begin
      src = clk_src_t'(i % 4);
      rnd = $urandom;
      {tx, ptx} = (i < 2) ? (i == 1 ? 16'hff00 : 16'h0180) : rnd[15:0];
      p_slave <= (src == SRC_SLAVE);
      p_rise  <= rnd[16];
      p_msb   <= rnd[17];
      p_tx    <= ptx;
      wr(IDX_MODE, {rnd[17], rnd[16], src});
      check("clk pd", {31'h0, src == SRC_SLAVE}, {31'h0, clk_pd});
      wr(IDX_DATA_LO, tx[3:0]);
      wr(IDX_DATA_HI, tx[7:4]);
      wr(IDX_IRQ_MASK, {3'h0, rnd[18]});
      wr(IDX_TRIGGER, 4'h5);
      p_arm <= 1'b1;
      @(posedge clk_i);
      p_arm <= 1'b0;
      check("pins", {29'h0, 2'b11, src != SRC_SLAVE}, {29'h0, route, func, !oe_n});
      wr(IDX_TRIGGER, 4'h7);
      rdchk(IDX_TRIGGER, 32'h7, "running");
      check("ready pin", {31'h0, src == SRC_SLAVE}, {31'h0, slave_ready_pin});
      if (src == SRC_SLAVE) begin
        p_go <= 1'b1;
        @(posedge clk_i);
        p_go <= 1'b0;
      end
      do rd(IDX_TRIGGER); while (rv[1] !== 1'b0);
      check("falls", 32'h8, {28'h0, p_falls});
      check("sent", {24'h0, wire_order(tx, rnd[17])}, {24'h0, p_rx});
      if (src != SRC_SLAVE) check("period", exp_period(src), last_gap);
      wr(IDX_TRIGGER, 4'h7);
      rdchk(IDX_TRIGGER, 32'h5, "rearm");
      rd(IDX_DATA_LO);
      rv2 = rv;
      rd(IDX_DATA_HI);
      check("received", {24'h0, ptx}, {24'h0, rv[3:0], rv2[3:0]});
      rdchk(IDX_IRQ_FLAG, 32'h1, "flag set");
      check("irq", {31'h0, rnd[18]}, {31'h0, irq});
      wr(IDX_IRQ_FLAG, 4'h0);
      rdchk(IDX_IRQ_FLAG, 32'h1, "flag kept");
      wr(IDX_IRQ_FLAG, 4'h1);
      rdchk(IDX_IRQ_FLAG, 32'h0, "flag clr");
      check("irq clr", 32'h0, {31'h0, irq});
    end
    test_done();
  end
endmodule

// file: sim/serial_peer_model.sv
`timescale 1ns/1ps
module serial_peer_model #(
  parameter int HALF = 63
) (
  input  wire logic       clk_i,
  input  wire logic       slave_i,
  input  wire logic       rise_i,
  input  wire logic       msb_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       arm_i,
  input  wire logic       go_i,
  input  wire logic       sclk_i,
  input  wire logic       serial_out_pin_i,
  input  wire logic       in_pd_i,
  input  wire logic       clk_pd_i,
  output logic            sclk_o,
  output logic            sin_o,
  output logic [7:0]      rx_o,
  output logic [3:0]      falls_o
);
  logic       prev_q = 1'b1;
  logic       gen_q  = 1'b0;
  logic       clk_q  = 1'b1;
  logic       drv_q  = 1'b0;
  logic       flip_q = 1'b0;
  logic [2:0] k_q    = 3'h0;
  int         gcnt   = 0;
  int         rises  = 0;
  int         hold   = 0;
  // A released line floats, so it shows the inverse of its last level unless pulled down.
  assign sclk_o = slave_i ? clk_q : (clk_pd_i ? 1'b0 : flip_q);
  assign sin_o  = drv_q ? (msb_i ? tx_i[3'h7-k_q] : tx_i[k_q]) : (in_pd_i ? 1'b0 : flip_q);
  initial begin
    rx_o    = 8'h00;
    falls_o = 4'h0;
  end
  always @(posedge clk_i) begin
    prev_q <= sclk_i;
    flip_q <= ~flip_q;
    if (arm_i) begin
      k_q     <= 3'h0;
      rises   <= 0;
      hold    <= 0;
      drv_q   <= 1'b1;
      falls_o <= 4'h0;
    end
    // Data moves on the edge opposite to the sampling edge, half a period clear of it.
    if (prev_q && !sclk_i) begin
      falls_o <= falls_o + 4'h1;
      rx_o    <= {rx_o[6:0], serial_out_pin_i};
      if (rise_i && falls_o != 4'h0 && k_q != 3'h7) k_q <= k_q + 3'h1;
    end
    if (!prev_q && sclk_i && drv_q) begin
      rises <= rises + 1;
      if (!rise_i && k_q != 3'h7) k_q <= k_q + 3'h1;
    end
    if (rises == 8 && drv_q) hold <= hold + 1;
    if (hold == 16) drv_q <= 1'b0;
    if (go_i) begin
      gen_q <= 1'b1;
      gcnt  <= 0;
    end else if (gen_q) begin
      gcnt <= gcnt + 1;
      if ((gcnt + 1) % HALF == 0) clk_q <= ~clk_q;
      if (gcnt + 1 == 16 * HALF) gen_q <= 1'b0;
    end
  end
endmodule
